/* design/mard_pkg.sv */
// constants and types for the multiply-accumulate and rotate datapath
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package mard_pkg;

    // operation select codes
    localparam logic [1:0] OP_REPEAT_MAC = 2'h0;
    localparam logic [1:0] OP_ROTATE_LEFT_THROUGH_CARRY = 2'h1;
    localparam logic [1:0] OP_ROTATE_RIGHT_THROUGH_CARRY = 2'h2;
    localparam logic [1:0] OP_MULTI_ROT = 2'h3;

    // pointer steps per iteration
    localparam logic [15:0] PTR_STEP_WORD = 16'h0002;
    localparam logic [15:0] PTR_STEP_BYTE = 16'h0001;

    // operand widths and sign bit positions
    localparam int BYTE_MSB = 7;
    localparam int WORD_MSB = 15;

    // flag vector layout for the load port
    localparam int FLAG_C_POS = 0;
    localparam int FLAG_Z_POS = 1;
    localparam int FLAG_S_POS = 2;
    localparam int FLAG_O_POS = 3;

    // reset values
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;
    localparam logic [15:0] REG16_RESET = 16'h0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    typedef enum logic [1:0] {
        MARD_IDLE,
        MARD_FETCH_A,
        MARD_FETCH_B,
        MARD_ACCUM
    } mard_state_t;

endpackage : mard_pkg

/* design/mard_datapath.sv */
// multiply-accumulate and rotate execution datapath
`timescale 1ns/100ps
module mard_datapath
    import mard_pkg::*;
(
    input wire logic mclk, // cpu clock, 25 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic op_start, // one-cycle start pulse
    input wire logic [1:0] op_sel, // operation select code
    input wire logic size_word, // 1 word size, 0 byte size
    input wire logic [31:0] acc_in, // accumulator pair start value
    input wire logic [15:0] mcand_ptr_in, // multiplicand pointer start
    input wire logic [15:0] mplier_ptr_in, // multiplier pointer start
    input wire logic [15:0] count_in, // iteration counter start
    input wire logic [15:0] dest_in, // rotate destination value
    input wire logic [7:0] rot_count, // signed multi-bit rotate count
    input wire logic irq_req, // pending interrupt request level
    input wire logic flag_load, // load flags from flag_wdata
    input wire logic [3:0] flag_wdata, // o,s,z,c flag values
    output logic mem_req, // operand read request
    output logic [15:0] mem_addr, // operand read address
    output logic mem_byte, // byte-size operand read
    input wire logic mem_ack, // read data valid pulse
    input wire logic [15:0] mem_rdata, // read data
    output logic [31:0] accumulator_pair, // accumulator, low is word
    output logic [15:0] multiplicand_pointer, // first operand pointer
    output logic [15:0] multiplier_pointer, // second operand pointer
    output logic [15:0] iteration_counter, // remaining iterations
    output logic [15:0] rot_result, // rotate result, byte in low bits
    output logic flag_s, // sign flag
    output logic flag_z, // zero flag
    output logic flag_c, // carry flag
    output logic flag_o, // overflow flag
    output logic busy, // multiply-accumulate in progress
    output logic op_done, // one-cycle completion pulse
    output logic irq_taken // one-cycle interrupt acceptance pulse
);

    //--------------------------------------------------------------------
    // state and operand registers
    //--------------------------------------------------------------------
    mard_state_t state;
    mard_state_t next_state;
    logic mac_word;
    logic [15:0] operand_a;
    logic [15:0] operand_b;

    //--------------------------------------------------------------------
    // decode of the start request
    //--------------------------------------------------------------------
    wire start_mac = op_start && (state == MARD_IDLE) &&
                     (op_sel == OP_REPEAT_MAC);
    wire start_rot = op_start && (state == MARD_IDLE) &&
                     (op_sel != OP_REPEAT_MAC);

    //--------------------------------------------------------------------
    // multiply-accumulate arithmetic
    //--------------------------------------------------------------------
    // operands are stored sign-extended, so one 16x16 multiplier serves
    // signed product
    wire signed [31:0] product = $signed(operand_a) * $signed(operand_b);
    // byte size accumulates into the low word only
    wire [32:0] acc_ext = mac_word ?
        {accumulator_pair[31], accumulator_pair} :
        {{17{accumulator_pair[15]}}, accumulator_pair[15:0]};
    // one guard bit is enough: a 16x16 product plus a 32-bit sum
    // can never carry two places past bit 31
    wire [32:0] sum = acc_ext + {product[31], product};
    wire ovf_word = sum[32] != sum[31];
    wire ovf_byte = !((&sum[32:15]) || !(|sum[32:15]));
    wire mac_ovf = mac_word ? ovf_word : ovf_byte;
    wire [31:0] acc_next = mac_word ? sum[31:0] :
                           {accumulator_pair[31:16], sum[15:0]};
    wire [15:0] ptr_step = mac_word ? PTR_STEP_WORD : PTR_STEP_BYTE;
    wire [15:0] count_dec = iteration_counter - 16'h0001;
    wire last_iter = (count_dec == 16'h0000);

    // byte reads sign-extend the low lane
    wire [15:0] rdata_ext = mac_word ? mem_rdata :
                            {{8{mem_rdata[BYTE_MSB]}}, mem_rdata[7:0]};

    //--------------------------------------------------------------------
    // one-bit rotates through carry
    //--------------------------------------------------------------------
    // operand width
    wire msb_in = size_word ? dest_in[WORD_MSB] : dest_in[BYTE_MSB];
    wire [15:0] rotate_left_through_carry_val = size_word ? {dest_in[14:0], flag_c} :
                           {8'h00, dest_in[6:0], flag_c};
    wire [15:0] rotate_right_through_carry_val = size_word ? {flag_c, dest_in[15:1]} :
                           {8'h00, flag_c, dest_in[7:1]};

    //--------------------------------------------------------------------
    // multi-bit rotate
    //--------------------------------------------------------------------
    // sign gives direction
    wire rot_right = rot_count[7];
    wire [7:0] rot_mag = rot_right ? (8'h00 - rot_count) : rot_count;
    // counts beyond the honoured range give an arbitrary but stable result
    // word range
    wire [4:0] rot_sh = rot_mag[4:0];
    wire rot_zero = (rot_count == 8'h00);
    // doubled operands let a full-width count fall out of the shifter
    // with no special case, at the price of a wider shift
    wire [15:0] byte_dbl = {dest_in[7:0], dest_in[7:0]};
    wire [31:0] word_dbl = {dest_in, dest_in};
    wire [15:0] byte_left = byte_dbl << rot_sh;
    wire [15:0] byte_right = byte_dbl >> rot_sh;
    wire [31:0] word_left = word_dbl << rot_sh;
    wire [31:0] word_right = word_dbl >> rot_sh;
    wire [15:0] rot_byte = {8'h00, rot_right ? byte_right[7:0] :
                                               byte_left[15:8]};
    wire [15:0] rot_word = rot_right ? word_right[15:0] : word_left[31:16];
    wire [15:0] mrot_val = size_word ? rot_word : rot_byte;
    // last bit out lands at the far end
    wire mrot_c = rot_right ? (size_word ? mrot_val[WORD_MSB] :
                                           mrot_val[BYTE_MSB]) :
                              mrot_val[0];

    //--------------------------------------------------------------------
    // rotate result and flag selection
    //--------------------------------------------------------------------
    wire [15:0] rot_val = (op_sel == OP_ROTATE_LEFT_THROUGH_CARRY) ? rotate_left_through_carry_val :
                          (op_sel == OP_ROTATE_RIGHT_THROUGH_CARRY) ? rotate_right_through_carry_val : mrot_val;
    wire rot_c = (op_sel == OP_ROTATE_LEFT_THROUGH_CARRY) ? msb_in :
                 (op_sel == OP_ROTATE_RIGHT_THROUGH_CARRY) ? dest_in[0] : mrot_c;
    wire rot_s = size_word ? rot_val[WORD_MSB] : rot_val[BYTE_MSB];
    wire rot_z = (rot_val == 16'h0000);
    wire rot_noop = (op_sel == OP_MULTI_ROT) && rot_zero;
    // a no-op still trims a byte operand, so the upper lane stays zero
    wire [15:0] dest_sized = size_word ? dest_in :
                             {8'h00, dest_in[BYTE_MSB:0]};

    //--------------------------------------------------------------------
    // memory request decode
    //--------------------------------------------------------------------
    // address is taken from the registered pointers, never from the adder,
    // so mem_addr holds steady through any number of wait states
    // a slow memory only stretches the fetch states; nothing times out,
    // so an answer that never comes leaves the block busy for good
    assign mem_req = (state == MARD_FETCH_A) || (state == MARD_FETCH_B);
    assign mem_addr = (state == MARD_FETCH_B) ? multiplier_pointer :
                                                multiplicand_pointer;
    assign mem_byte = !mac_word;
    assign busy = (state != MARD_IDLE);

    //--------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------
    // one iteration visits fetch a, fetch b and accumulate in turn;
    // the accumulate cycle is the only place where the loop may end
    always_comb begin
        next_state = state;
        case (state)
            MARD_IDLE: begin
                if (start_mac && (count_in != 16'h0000)) begin
                    next_state = MARD_FETCH_A;
                end
            end
            MARD_FETCH_A: begin
                if (mem_ack) begin
                    next_state = MARD_FETCH_B;
                end
            end
            MARD_FETCH_B: begin
                if (mem_ack) begin
                    next_state = MARD_ACCUM;
                end
            end
            MARD_ACCUM: begin
                // interrupt only at the iteration boundary
                // overflow outranks an interrupt so the flag is never lost
                if (mac_ovf || last_iter || irq_req) begin
                    next_state = MARD_IDLE;
                end else begin
                    next_state = MARD_FETCH_A;
                end
            end
            default: begin
                next_state = MARD_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= MARD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    //--------------------------------------------------------------------
    // operand capture
    //--------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            operand_a <= REG16_RESET;
            operand_b <= REG16_RESET;
        end else begin
            // held operands keep the multiplier steady while accumulating
            if ((state == MARD_FETCH_A) && mem_ack) begin
                operand_a <= rdata_ext;
            end
            if ((state == MARD_FETCH_B) && mem_ack) begin
                operand_b <= rdata_ext;
            end
        end
    end

    //--------------------------------------------------------------------
    // accumulator, pointers and counter
    //--------------------------------------------------------------------
    // the accumulator is loaded at each start and cleared only by reset: software owns its start
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            accumulator_pair <= ACC_RESET;
            multiplicand_pointer <= REG16_RESET;
            multiplier_pointer <= REG16_RESET;
            iteration_counter <= REG16_RESET;
            mac_word <= 1'b0;
        end else if (start_mac) begin
            accumulator_pair <= acc_in;
            multiplicand_pointer <= mcand_ptr_in;
            multiplier_pointer <= mplier_ptr_in;
            iteration_counter <= count_in;
            mac_word <= size_word;
        end else if (state == MARD_ACCUM) begin
            accumulator_pair <= acc_next;
            multiplicand_pointer <= multiplicand_pointer + ptr_step;
            multiplier_pointer <= multiplier_pointer + ptr_step;
            iteration_counter <= count_dec;
        end
    end

    //--------------------------------------------------------------------
    // flags and rotate result
    //--------------------------------------------------------------------
    // a flag load from the core yields to an accumulate cycle or a rotate start in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            {flag_o, flag_s, flag_z, flag_c} <= FLAGS_RESET;
            rot_result <= REG16_RESET;
        end else if (state == MARD_ACCUM) begin
            flag_o <= mac_ovf;
        end else if (start_rot) begin
            if (rot_noop) begin
                rot_result <= dest_sized;
            end else begin
                rot_result <= rot_val;
                flag_c <= rot_c;
                flag_z <= rot_z;
                flag_s <= rot_s;
            end
        end else if (flag_load) begin
            flag_c <= flag_wdata[FLAG_C_POS];
            flag_z <= flag_wdata[FLAG_Z_POS];
            flag_s <= flag_wdata[FLAG_S_POS];
            flag_o <= flag_wdata[FLAG_O_POS];
        end
    end

    //--------------------------------------------------------------------
    // completion and interrupt pulses
    //--------------------------------------------------------------------
    wire mac_stop = (state == MARD_ACCUM) && (mac_ovf || last_iter);
    wire irq_stop = (state == MARD_ACCUM) && !mac_ovf && !last_iter &&
                    irq_req;
    wire mac_skip = start_mac && (count_in == 16'h0000);

    // done pulse, one cycle after the accumulate cycle or the start
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            op_done <= 1'b0;
        end else begin
            op_done <= mac_stop || mac_skip || start_rot;
        end
    end

    // interrupt pulse; never together with done, as irq_stop excludes it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_taken <= 1'b0;
        end else begin
            irq_taken <= irq_stop;
        end
    end

endmodule // mard_datapath

/* sim/mard_checker.sv */
// concurrent checks on the datapath ports, bound to every instance
`timescale 1ns/100ps
module mard_checker
    import mard_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rst_n, // reset
    input wire logic op_start, // start
    input wire logic [1:0] op_sel, // op code
    input wire logic size_word, // size
    input wire logic [31:0] acc_in, // acc start
    input wire logic [15:0] count_in, // count start
    input wire logic [15:0] dest_in, // rotate operand
    input wire logic [7:0] rot_count, // rotate count
    input wire logic irq_req, // irq level
    input wire logic mem_req, // read request
    input wire logic [31:0] accumulator_pair, // acc
    input wire logic [15:0] iteration_counter, // count
    input wire logic [15:0] rot_result, // rotate result
    input wire logic flag_s, // sign
    input wire logic flag_z, // zero
    input wire logic flag_c, // carry
    input wire logic busy, // busy
    input wire logic op_done, // done pulse
    input wire logic irq_taken // irq pulse
);
    //----------------------------------------------------------------
    // start decode
    //----------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // accumulate cycle is the only busy cycle without a read request
    wire logic rot_go = op_start && !busy && op_sel != OP_REPEAT_MAC;
    wire logic mac_go = op_start && !busy && op_sel == OP_REPEAT_MAC;
    wire logic accum = busy && !mem_req;
    wire logic rot_zero = op_sel == OP_MULTI_ROT && rot_count == 8'h00;
    rot_done_a: assert property (rot_go |=> op_done)
        else $error("rotate without done pulse");
    rotate_left_through_carry_word_a: assert property (
        rot_go && op_sel == OP_ROTATE_LEFT_THROUGH_CARRY && size_word
        |=> rot_result == {$past(dest_in[14:0]), $past(flag_c)}
        && flag_c == $past(dest_in[15]))
        else $error("rotate left through carry wrong");
    rotate_right_through_carry_word_a: assert property (
        rot_go && op_sel == OP_ROTATE_RIGHT_THROUGH_CARRY && size_word
        |=> rot_result == {$past(flag_c), $past(dest_in[15:1])}
        && flag_c == $past(dest_in[0]))
        else $error("rotate right through carry wrong");
    rot_zero_a: assert property (
        rot_go && rot_zero |=> rot_result == ($past(size_word) ?
        $past(dest_in) : {8'h00, $past(dest_in[7:0])})
        && $stable({flag_s, flag_z, flag_c}))
        else $error("zero count changed state");
    rot_flags_a: assert property (
        rot_go && !rot_zero |=> flag_z == (rot_result == 16'h0000)
        && flag_s == ($past(size_word) ? rot_result[15] : rot_result[7]))
        else $error("rotate sign or zero flag wrong");
    byte_width_a: assert property (
        rot_go && !size_word |=> rot_result[15:8] == 8'h00)
        else $error("byte rotate leaked upper bits");
    mac_skip_a: assert property (
        mac_go && count_in == 16'h0000
        |=> op_done && !busy && accumulator_pair == $past(acc_in))
        else $error("zero count accumulate not skipped");
    count_dec_a: assert property (
        accum |=> iteration_counter == $past(iteration_counter) - 16'h0001)
        else $error("counter not decremented");
    irq_bound_a: assert property (
        irq_taken |-> $past(accum) && $past(irq_req) && !op_done)
        else $error("interrupt taken off boundary");
endmodule // mard_checker

bind mard_datapath mard_checker i_mard_checker (.*);

/* sim/test_mard_datapath.sv */
// self-checking bench for the accumulate and rotate datapath
`timescale 1ns/100ps
module test_mard_datapath
    import mard_pkg::*;
;
    logic mclk = 0, rst_n = 0, op_start = 0, size_word = 0, irq_req = 0;
    logic flag_load = 0, mem_ack = 0;
    logic [1:0] op_sel = 0;
    logic [3:0] flag_wdata = 0;
    logic [7:0] rot_count = 0;
    logic [31:0] acc_in = 0, accumulator_pair, e;
    logic [15:0] mcand_ptr_in = 0, mplier_ptr_in = 0, count_in = 0;
    logic [15:0] dest_in = 0, mem_rdata = 0, mem_addr, rot_result;
    logic [15:0] multiplicand_pointer, multiplier_pointer, iteration_counter;
    logic [15:0] ea, eb, ec, mem [256];
    logic mem_req, mem_byte, flag_s, flag_z, flag_c, flag_o, busy, eo;
    logic op_done, irq_taken;
    int error_cnt = 0, compares = 0;
    mard_datapath i_mard_datapath (.*);
    //----------------------------------------------------------------
    // clock and memory
    //----------------------------------------------------------------
    initial forever #20 mclk = ~mclk;
    // ack every other cycle; idle lane shows inverted data, not a hold
    always @(posedge mclk) begin
        #1;
        mem_ack <= mem_req && !mem_ack;
        mem_rdata <= !(mem_req && !mem_ack) ? ~mem_rdata : mem_byte ?
            {~mem[mem_addr[7:0]][15:8], mem[mem_addr[7:0]][7:0]} :
            mem[mem_addr[7:0]];
    end
    task chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, g, x);
        end
    endtask
    task results();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task setf(input logic [3:0] v);
        flag_wdata = v;
        flag_load = 1;
        @(posedge mclk);
        #1 flag_load = 0;
    endtask
    function automatic longint rd(input logic [15:0] a, input logic w);
        return w ? longint'($signed(mem[a[7:0]])) :
            longint'($signed(mem[a[7:0]][7:0]));
    endfunction
    // expected sum worked out bit-true, then compared after the pulse
    task mac(input logic w, input logic [31:0] a0,
        input logic [15:0] pa, pb, cnt, input logic irq);
        longint s;
        int k;
        logic stop, go;
        {e, ea, eb, ec, eo, stop} = {a0, pa, pb, cnt, 2'b10};
        setf(4'h8);
        while (ec != 0 && !stop) begin
            s = rd(ea, w) * rd(eb, w) + (w ? longint'($signed(e)) :
                longint'($signed(e[15:0])));
            eo = w ? (s > 64'sd2147483647 || s < -64'sd2147483648) :
                (s > 32767 || s < -32768);
            if (w) e = s[31:0];
            else e[15:0] = s[15:0];
            ea += w ? PTR_STEP_WORD : PTR_STEP_BYTE;
            eb += w ? PTR_STEP_WORD : PTR_STEP_BYTE;
            ec--;
            stop = eo || irq;
        end
        go = (cnt != 16'h0000);
        {op_sel, size_word, acc_in, count_in} = {OP_REPEAT_MAC, w, a0, cnt};
        {mcand_ptr_in, mplier_ptr_in, irq_req, op_start} = {pa, pb, irq, 1'b1};
        @(posedge mclk);
        #1 op_start = 0;
        chk({busy, mem_req, mem_byte, mem_addr}, {go, go, !w, pa});
        for (k = 0; k < 300 && op_done !== 1 && irq_taken !== 1; k++) begin
            @(posedge mclk);
            #1;
        end
        if (k == 300) begin
            chk(0, 1);
            results();
        end
        chk(irq_taken, irq && !eo && ec != 0);
        chk(accumulator_pair, e);
        chk(flag_o, eo);
        if (!eo || cnt == 16'h0000) begin
            chk({multiplicand_pointer, multiplier_pointer}, {ea, eb});
            chk(iteration_counter, ec);
        end
        irq_req = 0;
    endtask
    // carry preloaded, sign and zero preloaded opposite, overflow set
    task multi_bit_rotate(input logic [1:0] s, input logic w, input logic [15:0] d,
        input logic [7:0] n, input logic ci);
        logic [15:0] r, m;
        logic c;
        int t;
        setf({1'b1, ci, ~ci, ci});
        m = w ? 16'hFFFF : 16'h00FF;
        t = w ? 15 : 7;
        c = ci;
        r = d & m;
        if (s == OP_ROTATE_LEFT_THROUGH_CARRY) {c, r} = {r[t], ((r << 1) | ci) & m};
        if (s == OP_ROTATE_RIGHT_THROUGH_CARRY) {c, r} = {r[0], (r >> 1) | ({15'h0, ci} << t)};
        for (int i = 0; s == OP_MULTI_ROT && i < $signed(n); i++)
            {c, r} = {r[t], ((r << 1) | r[t]) & m};
        for (int i = 0; s == OP_MULTI_ROT && i > $signed(n); i--)
            {c, r} = {r[0], (r >> 1) | ({15'h0, r[0]} << t)};
        {op_sel, size_word, dest_in, rot_count, op_start} = {s, w, d, n, 1'b1};
        @(posedge mclk);
        #1 op_start = 0;
        chk({op_done, rot_result & m}, {1'b1, r});
        if (s == OP_MULTI_ROT && n == 8'h00)
            chk({flag_s, flag_z, flag_c}, {ci, ~ci, ci});
        else chk({flag_s, flag_z, flag_c}, {r[t], r == 0, c});
        chk(flag_o, 1);
    endtask
    //----------------------------------------------------------------
    // main sequence
    //----------------------------------------------------------------
    initial begin
        logic [15:0] d;
        for (int i = 0; i < 256; i++) mem[i] = 16'(i * 16'h03B5) ^ 16'h6A1C;
        for (int i = 240; i < 256; i++) mem[i] = 16'h7F80;
        repeat (8) @(posedge mclk);
        #1 rst_n = 1;
        chk(accumulator_pair, 32'h0);
        chk({rot_result, iteration_counter}, 32'h0);
        chk({busy, mem_req, flag_o, op_done, irq_taken}, 32'h0);
        @(posedge mclk);
        #1;
        mac(1, 32'h0000_0100, 16'h0010, 16'h0040, 16'h0003, 0);
        mac(0, 32'hA5A5_0007, 16'h0021, 16'h0055, 16'h0004, 0);
        mac(1, 32'h1234_5678, 16'h0030, 16'h0050, 16'h0000, 0);
        mac(1, 32'h0, 16'h00F0, 16'h00F2, 16'h0004, 0);
        mac(0, 32'h0, 16'h00F1, 16'h00F3, 16'h0004, 0);
        mac(1, 32'h10, 16'h0008, 16'h0060, 16'h0003, 1);
        mac(1, e, ea, eb, ec, 0);
        $display("accumulate tests done");
        for (int c = 0; c < 8; c++) begin
            d = c[2] ? 16'h8000 : 16'h8001;
            multi_bit_rotate(OP_ROTATE_LEFT_THROUGH_CARRY, c[1], d, 8'h00, c[0]);
            d = c[2] ? 16'h0001 : 16'h8001;
            multi_bit_rotate(OP_ROTATE_RIGHT_THROUGH_CARRY, c[1], d, 8'h00, c[0]);
        end
        // counts in range, apart from destination
        for (int w = 0; w < 2; w++)
            for (int k = -16; k <= 16; k++)
                if (w == 1 || (k >= -8 && k <= 8)) begin
                    d = 16'(16'h9C31 + k);
                    multi_bit_rotate(OP_MULTI_ROT, w[0], d, k[7:0], k[0]);
                end
        multi_bit_rotate(OP_MULTI_ROT, 1'b1, 16'h0000, 8'h03, 1'b1);
        multi_bit_rotate(OP_MULTI_ROT, 1'b0, 16'hA500, 8'hFD, 1'b1);
        $display("rotate tests done");
        results();
    end
endmodule // test_mard_datapath
